// file: include/icc_pkg.sv
/*
  Constants for the input capture channel: register addresses, control
  field positions, masks, reset values and capture mode codes.
  Assumes a 32-bit AHB-Lite register bus with word-aligned byte addresses.
*/
package icc_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'hBF80_2800;
  localparam logic [31:0] ADDR_CTRL_CLR = 32'hBF80_2804;
  localparam logic [31:0] ADDR_CTRL_SET = 32'hBF80_2808;
  localparam logic [31:0] ADDR_CTRL_INV = 32'hBF80_280C;
  localparam logic [31:0] ADDR_RESULT = 32'hBF80_2810;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hBF80_2820;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'hBF80_2824;
  localparam logic [31:0] ADDR_INT_FLAGS0 = 32'hBF88_1030;
  localparam logic [31:0] ADDR_INT_ENABLES0 = 32'hBF88_1060;
  localparam logic [31:0] ADDR_INT_PRIO4 = 32'hBF88_10D0;
  localparam logic [31:0] ADDR_INT_PRIO5 = 32'hBF88_10E0;

  // Control register fields
  localparam int CTRL_ON = 15;
  localparam int CTRL_DEBUG_FREEZE = 14;
  localparam int CTRL_IDLE_STOP = 13;
  localparam int CTRL_FIRST_EDGE = 9;
  localparam int CTRL_WIDTH32 = 8;
  localparam int CTRL_TIMER_SRC = 7;
  localparam int CTRL_RATE_LSB = 5;
  localparam int CTRL_OVERFLOW = 4;
  localparam int CTRL_NOT_EMPTY = 3;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_E3E7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Interrupt controller fields of the two channels
  localparam int INT_CH4_BIT = 17;
  localparam int INT_CH5_BIT = 21;
  localparam int PRIO_LSB = 10;
  localparam int SUBPRIO_LSB = 8;
  localparam logic [31:0] PRIO_MASK = 32'h0000_1F00;

  // Local event status and mask register
  localparam int STAT_CAPTURE_INT = 0;
  localparam int STAT_OVERFLOW = 1;
  localparam logic [1:0] STAT_RESET = 2'h0;

  // Capture modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
  localparam logic [2:0] MODE_FALLING = 3'h2;
  localparam logic [2:0] MODE_RISING = 3'h3;
  localparam logic [2:0] MODE_PRESCALE4 = 3'h4;
  localparam logic [2:0] MODE_PRESCALE16 = 3'h5;
  localparam logic [2:0] MODE_FIRST_THEN_ALL = 3'h6;
  localparam logic [2:0] MODE_INT_ONLY = 3'h7;

  localparam logic [3:0] PRESCALE4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE16_LAST = 4'hF;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } icc_bus_e;

endpackage

// file: core/icc_edge_detect.sv
/*
  Capture pin synchroniser, edge selection and prescaler for one channel.
  Assumes capture_pin is asynchronous to hclk; run gates prescaler, first-edge and event progress, not the synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module icc_edge_detect (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic chan_reset,
  input wire logic run,
  input wire logic [2:0] mode,
  input wire logic first_edge_select,
  input wire logic capture_pin,
  output logic capture_event,
  output logic wake_event
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic [3:0] prescale_reg;
  logic first_seen_reg;
  logic rise;
  logic fall;
  logic hit;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= capture_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_comb begin
    hit = 1'b0;
    case (mode)
      icc_pkg::MODE_EVERY_EDGE: hit = rise | fall;
      icc_pkg::MODE_FALLING: hit = fall;
      icc_pkg::MODE_RISING: hit = rise;
      icc_pkg::MODE_PRESCALE4: hit = rise && prescale_reg[1:0] == icc_pkg::PRESCALE4_LAST[1:0];
      icc_pkg::MODE_PRESCALE16: hit = rise && prescale_reg == icc_pkg::PRESCALE16_LAST;
      icc_pkg::MODE_FIRST_THEN_ALL: begin
        if (first_seen_reg) begin
          hit = rise | fall;
        end else begin
          hit = first_edge_select ? rise : fall;
        end
      end
      default: hit = 1'b0;
    endcase
  end

  // Prescaler is not cleared on a mode change, so disable before switching
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_reg <= 4'h0;
    end else if (chan_reset) begin
      prescale_reg <= 4'h0;
    end else if (run && rise) begin
      prescale_reg <= prescale_reg + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_seen_reg <= 1'b0;
    end else if (chan_reset || mode != icc_pkg::MODE_FIRST_THEN_ALL) begin
      first_seen_reg <= 1'b0;
    end else if (run && hit) begin
      first_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_event <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      capture_event <= run && !chan_reset && hit;
      wake_event <= run && !chan_reset && rise && mode == icc_pkg::MODE_INT_ONLY;
    end
  end

  a_first_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == icc_pkg::MODE_FIRST_THEN_ALL && !first_seen_reg && run && !chan_reset
     && !first_edge_select && rise) |=> !capture_event)
    else $error("first falling edge select captured a rising edge");

endmodule
`default_nettype wire

// file: core/icc_capture_channel.sv
/*
  Input capture channel: AHB-Lite register slave, control register with
  clear/set/invert aliases, single-entry capture result, decimated interrupt.
  Assumes timer counts come from hclk-domain logic and capture_pin is async.
*/
// Chosen here: the AHB-Lite register port.
// Function
// - Writing the clear alias clears control bits set in the written word.
// - Writing the set alias sets control bits that are one in the word.
// - Writing the invert alias toggles control bits that are one in the word.
// - Enable low holds the channel in reset, stopped, without interrupts.
// - With debug freeze set, the channel stops while the processor is in debug.
// - Debug freeze is writable only in debug mode, otherwise forced to zero.
// - With idle stop set, the channel halts while the processor idles.
// - In mode 110 first edge select picks rising or falling first capture.
// - Width select one captures a 32-bit timer, zero a 16-bit count.
// - In 16-bit capture, source zero takes timer three, one timer two.
// - Outside mode 001, interrupt rate raises an interrupt every first to fourth capture.
// - Overflow status at bit 4 reads one after a capture overflow.
// - Buffer not empty at bit 3 reads one while a value waits.
// - Mode field selects off, edge kinds, prescaled edges or interrupt only.
// - The result register returns the captured timer count.
`timescale 1ns/1ps
`default_nettype none
module icc_capture_channel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic capture_pin,
  input wire logic [15:0] timer_two_count,
  input wire logic [15:0] timer_three_count,
  input wire logic debug_mode,
  input wire logic idle_mode,
  output logic irq
);
  icc_pkg::icc_bus_e bus_state_reg;
  logic [31:0] addr_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] result_reg;
  logic not_empty_reg;
  logic overflow_reg;
  logic [1:0] dec_cnt_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic ch4_flag_reg;
  logic ch5_flag_reg;
  logic ch4_enable_reg;
  logic ch5_enable_reg;
  logic [4:0] prio4_reg;
  logic [4:0] prio5_reg;
  logic dbg_sync1_reg;
  logic dbg_sync2_reg;
  logic idle_sync1_reg;
  logic idle_sync2_reg;
  logic take;
  logic wr_en;
  logic rd_en;
  logic chan_on;
  logic run;
  logic [2:0] mode;
  logic [1:0] rate;
  logic capture_event;
  logic wake_event;
  logic capture_hit;
  logic int_event;
  logic overflow_set;
  logic [31:0] timer_value;
  logic [31:0] ctrl_view;

  // Mode pins from the core are asynchronous to the bus clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbg_sync1_reg <= 1'b0;
      dbg_sync2_reg <= 1'b0;
      idle_sync1_reg <= 1'b0;
      idle_sync2_reg <= 1'b0;
    end else begin
      dbg_sync1_reg <= debug_mode;
      dbg_sync2_reg <= dbg_sync1_reg;
      idle_sync1_reg <= idle_mode;
      idle_sync2_reg <= idle_sync1_reg;
    end
  end

  function automatic logic [31:0] ctrl_apply(input logic [31:0] cur, input logic [31:0] wd,
                                             input logic [31:0] addr, input logic dbg);
    logic [31:0] nxt;
    nxt = cur;
    if (addr == icc_pkg::ADDR_CTRL) begin
      nxt = wd;
    end else if (addr == icc_pkg::ADDR_CTRL_CLR) begin
      nxt = cur & ~wd;
    end else if (addr == icc_pkg::ADDR_CTRL_SET) begin
      nxt = cur | wd;
    end else if (addr == icc_pkg::ADDR_CTRL_INV) begin
      nxt = cur ^ wd;
    end
    nxt = nxt & icc_pkg::CTRL_WRITE_MASK;
    if (!dbg) begin
      nxt[icc_pkg::CTRL_DEBUG_FREEZE] = 1'b0;
    end
    return nxt;
  endfunction

  assign chan_on = ctrl_reg[icc_pkg::CTRL_ON];
  assign mode = ctrl_reg[icc_pkg::CTRL_MODE_LSB +: 3];
  assign rate = ctrl_reg[icc_pkg::CTRL_RATE_LSB +: 2];
  // Freeze and idle stop act as clock enables rather than gated clocks
  assign run = chan_on
    && !(ctrl_reg[icc_pkg::CTRL_DEBUG_FREEZE] && dbg_sync2_reg)
    && !(ctrl_reg[icc_pkg::CTRL_IDLE_STOP] && idle_sync2_reg);

  icc_edge_detect u_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .chan_reset(!chan_on),
    .run(run),
    .mode(mode),
    .first_edge_select(ctrl_reg[icc_pkg::CTRL_FIRST_EDGE]),
    .capture_pin(capture_pin),
    .capture_event(capture_event),
    .wake_event(wake_event)
  );

  // Bus slave: writes commit in the data phase, reads take one wait state
  // so that a write just before a read is already visible
  assign take = hsel && htrans[1] && hready;
  assign hreadyout = bus_state_reg != icc_pkg::BUS_READ_WAIT;
  assign hresp = 1'b0;
  assign wr_en = bus_state_reg == icc_pkg::BUS_WRITE;
  assign rd_en = bus_state_reg == icc_pkg::BUS_READ_WAIT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_reg <= icc_pkg::BUS_IDLE;
      addr_reg <= 32'h0000_0000;
    end else if (bus_state_reg == icc_pkg::BUS_READ_WAIT) begin
      bus_state_reg <= icc_pkg::BUS_READ_DONE;
    end else if (take) begin
      bus_state_reg <= hwrite ? icc_pkg::BUS_WRITE : icc_pkg::BUS_READ_WAIT;
      addr_reg <= haddr;
    end else begin
      bus_state_reg <= icc_pkg::BUS_IDLE;
    end
  end

  always_comb begin
    ctrl_view = ctrl_reg;
    ctrl_view[icc_pkg::CTRL_OVERFLOW] = overflow_reg;
    ctrl_view[icc_pkg::CTRL_NOT_EMPTY] = not_empty_reg;
  end

  // Alias and unmapped reads return zero; reserved bits read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (addr_reg == icc_pkg::ADDR_CTRL) begin
        hrdata <= ctrl_view;
      end else if (addr_reg == icc_pkg::ADDR_RESULT) begin
        hrdata <= result_reg;
      end else if (addr_reg == icc_pkg::ADDR_IRQ_STATUS) begin
        hrdata <= {30'h0000_0000, status_reg};
      end else if (addr_reg == icc_pkg::ADDR_IRQ_MASK) begin
        hrdata <= {30'h0000_0000, mask_reg};
      end else if (addr_reg == icc_pkg::ADDR_INT_FLAGS0) begin
        hrdata <= (32'(ch5_flag_reg) << icc_pkg::INT_CH5_BIT)
                | (32'(ch4_flag_reg) << icc_pkg::INT_CH4_BIT);
      end else if (addr_reg == icc_pkg::ADDR_INT_ENABLES0) begin
        hrdata <= (32'(ch5_enable_reg) << icc_pkg::INT_CH5_BIT)
                | (32'(ch4_enable_reg) << icc_pkg::INT_CH4_BIT);
      end else if (addr_reg == icc_pkg::ADDR_INT_PRIO4) begin
        hrdata <= 32'(prio4_reg) << icc_pkg::SUBPRIO_LSB;
      end else if (addr_reg == icc_pkg::ADDR_INT_PRIO5) begin
        hrdata <= 32'(prio5_reg) << icc_pkg::SUBPRIO_LSB;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Control register; configuration stays writable while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= icc_pkg::CTRL_RESET;
    end else if (wr_en) begin
      ctrl_reg <= ctrl_apply(ctrl_reg, hwdata, addr_reg, dbg_sync2_reg);
    end else if (!dbg_sync2_reg) begin
      ctrl_reg[icc_pkg::CTRL_DEBUG_FREEZE] <= 1'b0;
    end
  end

  // Timer source selection
  always_comb begin
    if (ctrl_reg[icc_pkg::CTRL_WIDTH32]) begin
      timer_value = {timer_three_count, timer_two_count};
    end else if (ctrl_reg[icc_pkg::CTRL_TIMER_SRC]) begin
      timer_value = {16'h0000, timer_two_count};
    end else begin
      timer_value = {16'h0000, timer_three_count};
    end
  end

  assign capture_hit = capture_event && mode != icc_pkg::MODE_INT_ONLY;
  // Edge detect mode never reports overflow and simply overwrites
  assign overflow_set = capture_hit && not_empty_reg && mode != icc_pkg::MODE_EVERY_EDGE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg <= 32'h0000_0000;
    end else if (!chan_on) begin
      result_reg <= 32'h0000_0000;
    end else if (capture_hit && !overflow_set) begin
      result_reg <= timer_value;
    end
  end

  // Capture sets win over the clearing read of the result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      not_empty_reg <= 1'b0;
    end else if (!chan_on) begin
      not_empty_reg <= 1'b0;
    end else if (capture_hit) begin
      not_empty_reg <= 1'b1;
    end else if (rd_en && addr_reg == icc_pkg::ADDR_RESULT) begin
      not_empty_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_reg <= 1'b0;
    end else if (!chan_on) begin
      overflow_reg <= 1'b0;
    end else if (overflow_set) begin
      overflow_reg <= 1'b1;
    end
  end

  // Interrupt decimation
  always_comb begin
    if (wake_event) begin
      int_event = 1'b1;
    end else if (!capture_hit) begin
      int_event = 1'b0;
    end else if (mode == icc_pkg::MODE_EVERY_EDGE) begin
      int_event = 1'b1;
    end else begin
      int_event = dec_cnt_reg == rate;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_cnt_reg <= 2'h0;
    end else if (!chan_on) begin
      dec_cnt_reg <= 2'h0;
    end else if (capture_hit && mode != icc_pkg::MODE_EVERY_EDGE) begin
      dec_cnt_reg <= (dec_cnt_reg == rate) ? 2'h0 : dec_cnt_reg + 2'h1;
    end
  end

  // Interrupt controller fields; hardware set wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch4_flag_reg <= 1'b0;
      ch5_flag_reg <= 1'b0;
      ch4_enable_reg <= 1'b0;
      ch5_enable_reg <= 1'b0;
      prio4_reg <= 5'h00;
      prio5_reg <= 5'h00;
    end else begin
      if (wr_en && addr_reg == icc_pkg::ADDR_INT_FLAGS0) begin
        ch4_flag_reg <= hwdata[icc_pkg::INT_CH4_BIT];
        ch5_flag_reg <= hwdata[icc_pkg::INT_CH5_BIT];
      end
      if (chan_on && int_event) begin
        ch5_flag_reg <= 1'b1;
      end
      if (wr_en && addr_reg == icc_pkg::ADDR_INT_ENABLES0) begin
        ch4_enable_reg <= hwdata[icc_pkg::INT_CH4_BIT];
        ch5_enable_reg <= hwdata[icc_pkg::INT_CH5_BIT];
      end
      if (wr_en && addr_reg == icc_pkg::ADDR_INT_PRIO4) begin
        prio4_reg <= hwdata[icc_pkg::SUBPRIO_LSB +: 5];
      end
      if (wr_en && addr_reg == icc_pkg::ADDR_INT_PRIO5) begin
        prio5_reg <= hwdata[icc_pkg::SUBPRIO_LSB +: 5];
      end
    end
  end

  // Local sticky status, cleared by reading it; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= icc_pkg::STAT_RESET;
      mask_reg <= icc_pkg::STAT_RESET;
    end else begin
      if (rd_en && addr_reg == icc_pkg::ADDR_IRQ_STATUS) begin
        status_reg <= {overflow_set, chan_on && int_event};
      end else begin
        status_reg[icc_pkg::STAT_CAPTURE_INT] <= status_reg[icc_pkg::STAT_CAPTURE_INT]
                                               | (chan_on && int_event);
        status_reg[icc_pkg::STAT_OVERFLOW] <= status_reg[icc_pkg::STAT_OVERFLOW] | overflow_set;
      end
      if (wr_en && addr_reg == icc_pkg::ADDR_IRQ_MASK) begin
        mask_reg <= hwdata[1:0];
      end
    end
  end

  // Interrupts stay blocked while the channel is disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= chan_on && ((ch5_flag_reg && ch5_enable_reg) || |(status_reg & mask_reg));
    end
  end

  a_clr_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_reg == icc_pkg::ADDR_CTRL_CLR) |=>
    ((ctrl_reg ^ ($past(ctrl_reg) & ~$past(hwdata))) & 32'h0000_A3E7) == 32'h0000_0000)
    else $error("clear alias changed the wrong control bits");

  a_set_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_reg == icc_pkg::ADDR_CTRL_SET) |=>
    ((ctrl_reg ^ (($past(ctrl_reg) | $past(hwdata)) & 32'h0000_E3E7)) & 32'h0000_A3E7)
    == 32'h0000_0000)
    else $error("set alias changed the wrong control bits");

  a_inv_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && addr_reg == icc_pkg::ADDR_CTRL_INV) |=>
    ((ctrl_reg ^ $past(ctrl_reg) ^ $past(hwdata)) & 32'h0000_A3E7) == 32'h0000_0000)
    else $error("invert alias did not toggle the written bits");

  a_freeze_forced: assert property (@(posedge hclk) disable iff (!hresetn)
    (!dbg_sync2_reg [*2]) |-> !ctrl_reg[icc_pkg::CTRL_DEBUG_FREEZE])
    else $error("debug freeze set outside debug mode");

  a_disable_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !chan_on |=> !not_empty_reg && dec_cnt_reg == 2'h0 && !irq)
    else $error("disabled channel kept state or interrupt");

  a_frozen_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_on && ctrl_reg[icc_pkg::CTRL_DEBUG_FREEZE] && dbg_sync2_reg) [*3] |=>
    $stable(result_reg))
    else $error("frozen channel captured a value");

  a_idle_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_on && ctrl_reg[icc_pkg::CTRL_IDLE_STOP] && idle_sync2_reg) [*3] |=>
    $stable(dec_cnt_reg))
    else $error("idle-stopped channel kept counting");

  a_width_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_on && capture_hit && !overflow_set && ctrl_reg[icc_pkg::CTRL_WIDTH32]) |=>
    result_reg == {$past(timer_three_count), $past(timer_two_count)})
    else $error("32-bit capture took the wrong value");

  a_source_sel: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_on && capture_hit && !overflow_set && !ctrl_reg[icc_pkg::CTRL_WIDTH32]) |=>
    result_reg[15:0] == ($past(ctrl_reg[icc_pkg::CTRL_TIMER_SRC]) ? $past(timer_two_count)
                                                                : $past(timer_three_count))
    && result_reg[31:16] == 16'h0000)
    else $error("16-bit capture took the wrong timer");

  a_rate_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_on && capture_hit && mode != icc_pkg::MODE_EVERY_EDGE && !wake_event) |->
    int_event == (dec_cnt_reg == rate))
    else $error("interrupt decimation miscounted");

  a_flag_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    (chan_on && int_event) |=> ch5_flag_reg ##1 (irq || !ch5_enable_reg || !chan_on))
    else $error("capture interrupt flag or request missing");

endmodule
`default_nettype wire

// file: verification/icc_far_model.sv
/* Far side: capture input level and the two timer counts.
   Assumes the bench sets the wanted values; outputs move on hclk. */
`timescale 1ns/1ps
`default_nettype none
module icc_far_model (
  input wire logic hclk,
  input wire logic pin_set,
  input wire logic [31:0] tim_set,
  output logic capture_pin,
  output logic [15:0] timer_two_count,
  output logic [15:0] timer_three_count
);
  // Registered, so each level lasts whole cycles as the synchroniser needs
  always_ff @(posedge hclk) begin
    capture_pin <= pin_set;
    {timer_three_count, timer_two_count} <= tim_set;
  end
endmodule
`default_nettype wire

// file: verification/test_input_capture_channel_control.sv
/* Bench: AHB-Lite master tasks, control register model, scenarios.
   Assumes icc_far_model stands on the capture side. */
`timescale 1ns/1ps
`default_nettype none
module test_input_capture_channel_control;
  localparam logic [31:0] CT = icc_pkg::ADDR_CTRL;
  localparam logic [31:0] RS = icc_pkg::ADDR_RESULT;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] tim = 32'h0;
  logic [31:0] rs = 32'h0000_DFE1;
  logic [31:0] hrdata, rd, cm, tv;
  logic [15:0] c2, c3;
  wire logic hready;
  logic irq, cp;
  logic pin = 1'b0;
  logic dbg = 1'b0;
  logic idl = 1'b0;
  logic [15:0] mc [5] = '{16'h8001, 16'h8002, 16'h8003, 16'h8006, 16'h8206};
  logic [4:0] eb = 5'h15;
  int fail_count = 0;
  int n_tests = 0;
  initial forever #2.5 hclk = ~hclk;
  icc_far_model i_icc_far_model (.hclk(hclk), .pin_set(pin), .tim_set(tim),
    .capture_pin(cp), .timer_two_count(c2), .timer_three_count(c3));
  icc_capture_channel i_icc_capture_channel (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(), .capture_pin(cp), .timer_two_count(c2), .timer_three_count(c3),
    .debug_mode(dbg), .idle_mode(idl), .irq(irq));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Bounded wait for hready; a hung slave ends the run
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (n >= 40) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic bx(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wt();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask
  task automatic pe(input logic l);
    pin <= l;
    repeat (8) @(posedge hclk);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bx(0, CT, 0);
    chk("ctrl rst", rd, icc_pkg::CTRL_RESET);
    bx(0, 32'hBF80_2830, 0);
    chk("unmapped", rd, 32'h0);
    cm = 32'h0;
    for (int i = 0; i < 12; i++) begin
      // Reserved control bits are always written as zero
      tv = rnd() & icc_pkg::CTRL_WRITE_MASK;
      bx(1, icc_pkg::ADDR_CTRL_CLR + 32'(4 * (i % 3)), tv);
      case (i % 3)
        0: cm = cm & ~tv;
        1: cm = cm | tv;
        default: cm = cm ^ tv;
      endcase
      cm = cm & 32'h0000_A3E7;
      bx(0, CT, 0);
      chk("alias", rd, cm);
    end
    bx(1, CT, 32'h0);
    bx(1, icc_pkg::ADDR_INT_ENABLES0, 32'h0020_0000);
    for (int r = 0; r < 4; r++) begin
      tv = 32'h0000_8003 | 32'(r << 5) | 32'(r[1]) << 8 | 32'(r[0]) << 7;
      bx(1, CT, tv);
      if (r > 0) begin
        pe(1'b1);
        pe(1'b0);
        bx(1, CT, 32'h0);
        bx(1, CT, tv);
      end
      for (int k = 0; k <= r; k++) begin
        tim <= rnd();
        pe(1'b1);
        pe(1'b0);
        chk("irq rate", irq, k == r);
        bx(0, RS, 0);
        chk("result", rd, r[1] ? tim : {16'h0, r[0] ? tim[15:0] : tim[31:16]});
      end
      bx(0, icc_pkg::ADDR_INT_FLAGS0, 0);
      chk("flag", rd & 32'h0020_0000, 32'h0020_0000);
      bx(1, icc_pkg::ADDR_INT_FLAGS0, 32'h0);
      bx(1, CT, 32'h0);
    end
    bx(1, icc_pkg::ADDR_INT_ENABLES0, 32'h0);
    bx(1, CT, 32'h0000_8003);
    tim <= 32'h5A5A_0000;
    pe(1'b1);
    pe(1'b0);
    tim <= rnd();
    pe(1'b1);
    pe(1'b0);
    chk("irq off", irq, 1'b0);
    bx(0, CT, 0);
    chk("ovf", rd, 32'h0000_801B);
    bx(0, RS, 0);
    chk("kept", rd, 32'h0000_5A5A);
    bx(0, CT, 0);
    chk("bne", rd, 32'h0000_8013);
    bx(1, CT, 32'h0);
    bx(0, RS, 0);
    chk("off", rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      bx(1, CT, 32'h0);
      bx(1, CT, {16'h0, mc[i]});
      pe(1'b1);
      bx(0, CT, 0);
      chk("edge", rd[3], eb[i]);
      pe(1'b0);
    end
    for (int p = 0; p < 2; p++) begin
      bx(1, CT, 32'h0);
      bx(1, CT, 32'h0000_8004 + 32'(p));
      for (int k = 0; k < (p ? 16 : 4); k++) begin
        bx(0, CT, 0);
        chk("presc", rd[3], 1'b0);
        pe(1'b1);
        pe(1'b0);
      end
      bx(0, CT, 0);
      chk("presc hit", rd[3], 1'b1);
    end
    dbg <= 1'b1;
    bx(1, CT, 32'h0);
    bx(1, CT, 32'h0000_C003);
    pe(1'b1);
    pe(1'b0);
    bx(0, CT, 0);
    chk("frozen", rd, 32'h0000_C003);
    dbg <= 1'b0;
    idl <= 1'b1;
    bx(1, CT, 32'h0);
    bx(1, CT, 32'h0000_A003);
    pe(1'b1);
    pe(1'b0);
    bx(0, CT, 0);
    chk("idle", rd, 32'h0000_A003);
    idl <= 1'b0;
    bx(1, CT, 32'h0);
    // Earlier captures and the overflow left both sticky status bits set
    bx(0, icc_pkg::ADDR_IRQ_STATUS, 0);
    chk("stat old", rd, 32'h3);
    bx(1, icc_pkg::ADDR_IRQ_MASK, 32'h1);
    bx(1, CT, 32'h0000_8007);
    chk("irq idle", irq, 1'b0);
    pe(1'b1);
    pe(1'b0);
    chk("irq int", irq, 1'b1);
    bx(0, icc_pkg::ADDR_IRQ_STATUS, 0);
    chk("status", rd, 32'h1);
    bx(0, icc_pkg::ADDR_IRQ_STATUS, 0);
    chk("stat clr", rd, 32'h0);
    chk("irq clr", irq, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
